// [core/pfs_consts.svh]
// Constants for the pin function selector: offsets, masks, fields, input source bits.
// Assumes inclusion by the package and the modules of this block only.
`ifndef PFS_CONSTS_SVH
`define PFS_CONSTS_SVH

// Register offsets on the byte-wide register port.
`define PFS_ADR_PB_LO  3'h0
`define PFS_ADR_PB_HI  3'h1
`define PFS_ADR_PC_LO  3'h2
`define PFS_ADR_PC_HI  3'h3
`define PFS_ADR_PD     3'h4
`define PFS_ADR_IN_SRC 3'h5

// Reset value and writable masks.
`define PFS_RST_SEL    8'h00
`define PFS_MASK_FULL  8'hFF
`define PFS_MASK_LOW6  8'h3F

// Field positions, low bit of each two-bit field.
`define PFS_FLD_L0     0
`define PFS_FLD_L1     2
`define PFS_FLD_L2     4
`define PFS_FLD_L3     6

// Bit positions in the input source register.
`define PFS_IS_IRQ1    5
`define PFS_IS_IRQ0    4
`define PFS_IS_DIN     3
`define PFS_IS_SCK     2
`define PFS_IS_CSEL    1
`define PFS_IS_RX      0

`endif

// [core/pfs_pkg.sv]
// Types shared by the pin function selector modules.
// Assumes the constants header sits beside it.
package pfs_pkg;
  `include "pfs_consts.svh"

  // One selector register byte.
  typedef logic [7:0] pfs_byte_t;

  // Two-bit function code of one pin.
  typedef enum logic [1:0] {
    PFS_CODE_0 = 2'b00,
    PFS_CODE_1 = 2'b01,
    PFS_CODE_2 = 2'b10,
    PFS_CODE_3 = 2'b11
  } pfs_code_e;
endpackage

// [core/pfs_sync.sv]
// Three-stage synchroniser for pad inputs with agreement filter.
// Assumes the inputs are asynchronous to CLK_I of the parent.
`timescale 1ns/1ps
module pfs_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  // Raw and filtered levels.
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_q, s2_q, s3_q, q_q, q_d;

  // A change is taken once the second and third stages agree.
  always_comb begin
    for (int i = 0; i < W; i++) begin
      q_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : q_q[i];
    end
  end

  // The first stage feeds only the second.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q_q  <= '0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q_q  <= q_d;
    end
  end

  assign q_o = q_q;
endmodule

// [core/pfs_pad_cell.sv]
// Output steering of one shared pin from its two-bit function code.
// Assumes the port logic and peripherals sit on the same clock.
`timescale 1ns/1ps
module pfs_pad_cell import pfs_pkg::*; #(
  parameter logic [3:0] GPIO_MAP = 4'h1,
  parameter logic [3:0] ANA_MAP  = 4'hC
) (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  // Function code and drive sources.
  input  wire logic [1:0] code_i,
  input  wire logic       gpio_out_i,
  input  wire logic       gpio_oe_i,
  input  wire logic [3:0] alt_out_i,
  input  wire logic [3:0] alt_oe_i,
  // Pad drive and analog connect.
  output logic            pad_out_o,
  output logic            pad_oe_o,
  output logic            ana_o
);
  logic out_d, oe_d, ana_d;
  logic out_q, oe_q, ana_q;

  // General I/O codes take the latch, peripheral codes the peripheral.
  always_comb begin
    ana_d = ANA_MAP[code_i];
    if (GPIO_MAP[code_i]) begin
      out_d = gpio_out_i;
      oe_d  = gpio_oe_i;
    end else begin
      out_d = alt_out_i[code_i] & alt_oe_i[code_i];
      oe_d  = alt_oe_i[code_i];
    end
  end

  // Registered pad drive; reset leaves the pin released.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      out_q <= 1'b0;
      oe_q  <= 1'b0;
      ana_q <= 1'b0;
    end else begin
      out_q <= out_d;
      oe_q  <= oe_d;
      ana_q <= ana_d;
    end
  end

  assign pad_out_o = out_q;
  assign pad_oe_o  = oe_q;
  assign ana_o     = ana_q;
endmodule

// [core/pfs_pin_function_selector.sv]
// Pin function selector: selector registers, pad steering, input routing.
// Assumes port data/direction logic and peripherals share CLK_I.
`timescale 1ns/1ps
`include "pfs_consts.svh"
module pfs_pin_function_selector import pfs_pkg::*; (
  // Clock and reset.
  input  wire logic       CLK_I,
  input  wire logic       SRST_I,
  // Register port.
  input  wire logic [2:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic      [7:0] RDATA_O,
  // Port A pad inputs, lines 1 to 3.
  input  wire logic [3:1] PA_PAD_I,
  // Port B pads and port latch.
  input  wire logic [6:0] PB_PAD_I,
  input  wire logic [6:0] PB_GPIO_OUT_I,
  input  wire logic [6:0] PB_GPIO_OE_I,
  output logic      [6:0] PB_PAD_OUT_O,
  output logic      [6:0] PB_PAD_OE_O,
  output logic      [6:0] PB_ANALOG_O,
  // Port C pads and port latch.
  input  wire logic [6:0] PC_PAD_I,
  input  wire logic [6:0] PC_GPIO_OUT_I,
  input  wire logic [6:0] PC_GPIO_OE_I,
  output logic      [6:0] PC_PAD_OUT_O,
  output logic      [6:0] PC_PAD_OE_O,
  output logic      [6:0] PC_ANALOG_O,
  // Port D pads and port latch.
  input  wire logic [3:0] PD_PAD_I,
  input  wire logic [3:0] PD_GPIO_OUT_I,
  input  wire logic [3:0] PD_GPIO_OE_I,
  output logic      [3:0] PD_PAD_OUT_O,
  output logic      [3:0] PD_PAD_OE_O,
  output logic      [3:0] PD_ANALOG_O,
  // Peripheral outputs toward the pins.
  input  wire logic       CTIMER_OUT_I,
  input  wire logic       STIMER_OUT_I,
  input  wire logic       CHIP_SEL_OUT_I,
  input  wire logic       CHIP_SEL_OE_I,
  input  wire logic       SER_DATA_OUT_I,
  input  wire logic       SER_TX_I,
  // Pin levels routed to peripherals.
  output logic            EXT_IRQ_ZERO_O,
  output logic            EXT_IRQ_ONE_O,
  output logic            STIMER_CLK_IN_O,
  output logic            SER_DATA_IN_O,
  output logic            SER_CLK_IN_O,
  output logic            CHIP_SEL_IN_O,
  output logic            SER_RX_O
);
  // Selector registers.
  pfs_byte_t pb_lo_q, pb_hi_q, pc_lo_q, pc_hi_q, pd_q, src_q;
  pfs_byte_t pb_lo_d, pb_hi_d, pc_lo_d, pc_hi_d, pd_d, src_d;
  pfs_byte_t rdata_q, rdata_d;

  // Filtered pad levels.
  logic [3:1] pa_s;
  logic [6:0] pb_s;
  logic [6:0] pc_s;
  logic [3:0] pd_s;

  // Routed peripheral inputs.
  logic irq0_d, irq1_d, tclk_d, din_d, sck_d, csel_d, rx_d;
  logic irq0_q, irq1_q, tclk_q, din_q, sck_q, csel_q, rx_q;

  // Pad drive from the steering cells.
  logic [6:0] pb_out, pb_oe, pb_ana;
  logic [6:0] pc_out, pc_oe, pc_ana;
  logic [3:0] pd_out, pd_oe, pd_ana;

  // Pins whose codes are outside this block pass the latch.
  logic [1:0] pbp_out_d, pbp_oe_d, pbp_out_q, pbp_oe_q;
  logic [1:0] pcp_out_d, pcp_oe_d, pcp_out_q, pcp_oe_q;
  logic [2:0] pdp_out_d, pdp_oe_d, pdp_out_q, pdp_oe_q;

  // Register writes and read data; unmapped reads return zero.
  always_comb begin
    pb_lo_d = pb_lo_q;
    pb_hi_d = pb_hi_q;
    pc_lo_d = pc_lo_q;
    pc_hi_d = pc_hi_q;
    pd_d    = pd_q;
    src_d   = src_q;
    rdata_d = 8'h00;
    if (WR_I) begin
      unique case (ADDR_I)
        `PFS_ADR_PB_LO:  pb_lo_d = WDATA_I & `PFS_MASK_FULL;
        `PFS_ADR_PB_HI:  pb_hi_d = WDATA_I & `PFS_MASK_LOW6;
        `PFS_ADR_PC_LO:  pc_lo_d = WDATA_I & `PFS_MASK_FULL;
        `PFS_ADR_PC_HI:  pc_hi_d = WDATA_I & `PFS_MASK_LOW6;
        `PFS_ADR_PD:     pd_d    = WDATA_I & `PFS_MASK_FULL;
        `PFS_ADR_IN_SRC: src_d   = WDATA_I & `PFS_MASK_LOW6;
        default: ;
      endcase
    end
    if (RD_I) begin
      unique case (ADDR_I)
        `PFS_ADR_PB_LO:  rdata_d = pb_lo_q;
        `PFS_ADR_PB_HI:  rdata_d = pb_hi_q;
        `PFS_ADR_PC_LO:  rdata_d = pc_lo_q;
        `PFS_ADR_PC_HI:  rdata_d = pc_hi_q;
        `PFS_ADR_PD:     rdata_d = pd_q;
        `PFS_ADR_IN_SRC: rdata_d = src_q;
        default:         rdata_d = 8'h00;
      endcase
    end
  end

  // Register storage.
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      pb_lo_q <= `PFS_RST_SEL;
      pb_hi_q <= `PFS_RST_SEL;
      pc_lo_q <= `PFS_RST_SEL;
      pc_hi_q <= `PFS_RST_SEL;
      pd_q    <= `PFS_RST_SEL;
      src_q   <= `PFS_RST_SEL;
      rdata_q <= 8'h00;
    end else begin
      pb_lo_q <= pb_lo_d;
      pb_hi_q <= pb_hi_d;
      pc_lo_q <= pc_lo_d;
      pc_hi_q <= pc_hi_d;
      pd_q    <= pd_d;
      src_q   <= src_d;
      rdata_q <= rdata_d;
    end
  end

  assign RDATA_O = rdata_q;

  // Pad inputs are asynchronous and pass the filter first.
  pfs_sync #(.W(21)) u_sync (
    .clk_i  (CLK_I),
    .srst_i (SRST_I),
    .d_i    ({PA_PAD_I, PB_PAD_I, PC_PAD_I, PD_PAD_I}),
    .q_o    ({pa_s, pb_s, pc_s, pd_s})
  );

  // Input source choices for the peripheral inputs.
  always_comb begin
    irq1_d = src_q[`PFS_IS_IRQ1] ? pa_s[2] : pb_s[1];
    irq0_d = src_q[`PFS_IS_IRQ0] ? pa_s[1] : pb_s[0];
    csel_d = src_q[`PFS_IS_CSEL] ? pb_s[5] : pc_s[6];
    din_d  = src_q[`PFS_IS_DIN] ? pa_s[3] : pc_s[4];
    sck_d  = src_q[`PFS_IS_SCK] ? pb_s[6] : pc_s[5];
    rx_d   = src_q[`PFS_IS_RX] ? pc_s[1] : pd_s[1];
    // timer clock only on code 00
    tclk_d = (pb_lo_q[5:4] == PFS_CODE_0) & pb_s[2];
  end

  // Routed inputs are registered; the pin direction is software's job.
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      irq0_q <= 1'b0;
      irq1_q <= 1'b0;
      tclk_q <= 1'b0;
      din_q  <= 1'b0;
      sck_q  <= 1'b0;
      csel_q <= 1'b0;
      rx_q   <= 1'b0;
    end else begin
      irq0_q <= irq0_d;
      irq1_q <= irq1_d;
      tclk_q <= tclk_d;
      din_q  <= din_d;
      sck_q  <= sck_d;
      csel_q <= csel_d;
      rx_q   <= rx_d;
    end
  end

  assign EXT_IRQ_ZERO_O  = irq0_q;
  assign EXT_IRQ_ONE_O   = irq1_q;
  assign STIMER_CLK_IN_O = tclk_q;
  assign SER_DATA_IN_O   = din_q;
  assign SER_CLK_IN_O    = sck_q;
  assign CHIP_SEL_IN_O   = csel_q;
  assign SER_RX_O        = rx_q;

  pfs_pad_cell #(.GPIO_MAP(4'h1), .ANA_MAP(4'hE)) u_pb0 (
    .clk_i      (CLK_I),
    .srst_i     (SRST_I),
    .code_i     (pb_lo_q[`PFS_FLD_L0 +: 2]),
    .gpio_out_i (PB_GPIO_OUT_I[0]),
    .gpio_oe_i  (PB_GPIO_OE_I[0]),
    .alt_out_i  (4'h0),
    .alt_oe_i   (4'h0),
    .pad_out_o  (pb_out[0]),
    .pad_oe_o   (pb_oe[0]),
    .ana_o      (pb_ana[0])
  );

  pfs_pad_cell #(.GPIO_MAP(4'h1), .ANA_MAP(4'hE)) u_pb1 (
    .clk_i      (CLK_I),
    .srst_i     (SRST_I),
    .code_i     (pb_lo_q[`PFS_FLD_L1 +: 2]),
    .gpio_out_i (PB_GPIO_OUT_I[1]),
    .gpio_oe_i  (PB_GPIO_OE_I[1]),
    .alt_out_i  (4'h0),
    .alt_oe_i   (4'h0),
    .pad_out_o  (pb_out[1]),
    .pad_oe_o   (pb_oe[1]),
    .ana_o      (pb_ana[1])
  );

  pfs_pad_cell #(.GPIO_MAP(4'h1), .ANA_MAP(4'hC)) u_pb2 (
    .clk_i      (CLK_I),
    .srst_i     (SRST_I),
    .code_i     (pb_lo_q[`PFS_FLD_L2 +: 2]),
    .gpio_out_i (PB_GPIO_OUT_I[2]),
    .gpio_oe_i  (PB_GPIO_OE_I[2]),
    .alt_out_i  ({2'b00, STIMER_OUT_I, 1'b0}),
    .alt_oe_i   (4'h2),
    .pad_out_o  (pb_out[2]),
    .pad_oe_o   (pb_oe[2]),
    .ana_o      (pb_ana[2])
  );

  pfs_pad_cell #(.GPIO_MAP(4'h1), .ANA_MAP(4'hC)) u_pb3 (
    .clk_i      (CLK_I),
    .srst_i     (SRST_I),
    .code_i     (pb_lo_q[`PFS_FLD_L3 +: 2]),
    .gpio_out_i (PB_GPIO_OUT_I[3]),
    .gpio_oe_i  (PB_GPIO_OE_I[3]),
    .alt_out_i  ({2'b00, CTIMER_OUT_I, 1'b0}),
    .alt_oe_i   (4'h2),
    .pad_out_o  (pb_out[3]),
    .pad_oe_o   (pb_oe[3]),
    .ana_o      (pb_ana[3])
  );

  // B5 steering; chip select drives only when enabled
  pfs_pad_cell #(.GPIO_MAP(4'h1), .ANA_MAP(4'hC)) u_pb5 (
    .clk_i      (CLK_I),
    .srst_i     (SRST_I),
    .code_i     (pb_hi_q[`PFS_FLD_L1 +: 2]),
    .gpio_out_i (PB_GPIO_OUT_I[5]),
    .gpio_oe_i  (PB_GPIO_OE_I[5]),
    .alt_out_i  ({2'b00, CHIP_SEL_OUT_I, 1'b0}),
    .alt_oe_i   ({2'b00, CHIP_SEL_OE_I, 1'b0}),
    .pad_out_o  (pb_out[5]),
    .pad_oe_o   (pb_oe[5]),
    .ana_o      (pb_ana[5])
  );

  pfs_pad_cell #(.GPIO_MAP(4'h1), .ANA_MAP(4'hC)) u_pc0 (
    .clk_i      (CLK_I),
    .srst_i     (SRST_I),
    .code_i     (pc_lo_q[`PFS_FLD_L0 +: 2]),
    .gpio_out_i (PC_GPIO_OUT_I[0]),
    .gpio_oe_i  (PC_GPIO_OE_I[0]),
    .alt_out_i  ({2'b00, SER_TX_I, 1'b0}),
    .alt_oe_i   (4'h2),
    .pad_out_o  (pc_out[0]),
    .pad_oe_o   (pc_oe[0]),
    .ana_o      (pc_ana[0])
  );

  // C1 steering; receive code leaves the driver off
  pfs_pad_cell #(.GPIO_MAP(4'h1), .ANA_MAP(4'hC)) u_pc1 (
    .clk_i      (CLK_I),
    .srst_i     (SRST_I),
    .code_i     (pc_lo_q[`PFS_FLD_L1 +: 2]),
    .gpio_out_i (PC_GPIO_OUT_I[1]),
    .gpio_oe_i  (PC_GPIO_OE_I[1]),
    .alt_out_i  (4'h0),
    .alt_oe_i   (4'h0),
    .pad_out_o  (pc_out[1]),
    .pad_oe_o   (pc_oe[1]),
    .ana_o      (pc_ana[1])
  );

  pfs_pad_cell #(.GPIO_MAP(4'h3), .ANA_MAP(4'h8)) u_pc2 (
    .clk_i      (CLK_I),
    .srst_i     (SRST_I),
    .code_i     (pc_lo_q[`PFS_FLD_L2 +: 2]),
    .gpio_out_i (PC_GPIO_OUT_I[2]),
    .gpio_oe_i  (PC_GPIO_OE_I[2]),
    .alt_out_i  ({1'b0, SER_DATA_OUT_I, 2'b00}),
    .alt_oe_i   (4'h4),
    .pad_out_o  (pc_out[2]),
    .pad_oe_o   (pc_oe[2]),
    .ana_o      (pc_ana[2])
  );

  pfs_pad_cell #(.GPIO_MAP(4'h3), .ANA_MAP(4'h8)) u_pc3 (
    .clk_i      (CLK_I),
    .srst_i     (SRST_I),
    .code_i     (pc_lo_q[`PFS_FLD_L3 +: 2]),
    .gpio_out_i (PC_GPIO_OUT_I[3]),
    .gpio_oe_i  (PC_GPIO_OE_I[3]),
    .alt_out_i  ({1'b0, SER_DATA_OUT_I, 2'b00}),
    .alt_oe_i   (4'h4),
    .pad_out_o  (pc_out[3]),
    .pad_oe_o   (pc_oe[3]),
    .ana_o      (pc_ana[3])
  );

  // C4 steering; data-in code leaves the driver off
  pfs_pad_cell #(.GPIO_MAP(4'h3), .ANA_MAP(4'h8)) u_pc4 (
    .clk_i      (CLK_I),
    .srst_i     (SRST_I),
    .code_i     (pc_hi_q[`PFS_FLD_L0 +: 2]),
    .gpio_out_i (PC_GPIO_OUT_I[4]),
    .gpio_oe_i  (PC_GPIO_OE_I[4]),
    .alt_out_i  (4'h0),
    .alt_oe_i   (4'h0),
    .pad_out_o  (pc_out[4]),
    .pad_oe_o   (pc_oe[4]),
    .ana_o      (pc_ana[4])
  );

  pfs_pad_cell #(.GPIO_MAP(4'h1), .ANA_MAP(4'hC)) u_pd3 (
    .clk_i      (CLK_I),
    .srst_i     (SRST_I),
    .code_i     (pd_q[`PFS_FLD_L3 +: 2]),
    .gpio_out_i (PD_GPIO_OUT_I[3]),
    .gpio_oe_i  (PD_GPIO_OE_I[3]),
    .alt_out_i  ({2'b00, CTIMER_OUT_I, 1'b0}),
    .alt_oe_i   (4'h2),
    .pad_out_o  (pd_out[3]),
    .pad_oe_o   (pd_oe[3]),
    .ana_o      (pd_ana[3])
  );

  // Lines without steering here follow the port latch.
  always_comb begin
    pbp_out_d = {PB_GPIO_OUT_I[6], PB_GPIO_OUT_I[4]};
    pbp_oe_d  = {PB_GPIO_OE_I[6], PB_GPIO_OE_I[4]};
    pcp_out_d = PC_GPIO_OUT_I[6:5];
    pcp_oe_d  = PC_GPIO_OE_I[6:5];
    pdp_out_d = PD_GPIO_OUT_I[2:0];
    pdp_oe_d  = PD_GPIO_OE_I[2:0];
  end

  // Same one-cycle latency as the steered lines.
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      pbp_out_q <= 2'h0;
      pbp_oe_q  <= 2'h0;
      pcp_out_q <= 2'h0;
      pcp_oe_q  <= 2'h0;
      pdp_out_q <= 3'h0;
      pdp_oe_q  <= 3'h0;
    end else begin
      pbp_out_q <= pbp_out_d;
      pbp_oe_q  <= pbp_oe_d;
      pcp_out_q <= pcp_out_d;
      pcp_oe_q  <= pcp_oe_d;
      pdp_out_q <= pdp_out_d;
      pdp_oe_q  <= pdp_oe_d;
    end
  end

  // Unsteered bits of the cell vectors are filled by the pass path.
  assign pb_out[4] = pbp_out_q[0];
  assign pb_out[6] = pbp_out_q[1];
  assign pb_oe[4]  = pbp_oe_q[0];
  assign pb_oe[6]  = pbp_oe_q[1];
  assign pb_ana[4] = 1'b0;
  assign pb_ana[6] = 1'b0;
  assign pc_out[6:5] = pcp_out_q;
  assign pc_oe[6:5]  = pcp_oe_q;
  assign pc_ana[6:5] = 2'b00;
  assign pd_out[2:0] = pdp_out_q;
  assign pd_oe[2:0]  = pdp_oe_q;
  assign pd_ana[2:0] = 3'h0;

  // Pad outputs.
  assign PB_PAD_OUT_O = pb_out;
  assign PB_PAD_OE_O  = pb_oe;
  assign PB_ANALOG_O  = pb_ana;
  assign PC_PAD_OUT_O = pc_out;
  assign PC_PAD_OE_O  = pc_oe;
  assign PC_ANALOG_O  = pc_ana;
  assign PD_PAD_OUT_O = pd_out;
  assign PD_PAD_OE_O  = pd_oe;
  assign PD_ANALOG_O  = pd_ana;
endmodule

// [core/pfs_top_unused_placeholder.sv]
// Intentionally empty.

// [test/pfs_pin_function_selector_asserts.sv]
// Checker for the pin function selector: register port and pad steering.
// Assumes one clock, CLK_I, and the synchronous active high reset SRST_I.
`timescale 1ns/1ps
module pfs_sel_checker (
  // Clock and reset.
  input wire logic       CLK_I,
  input wire logic       SRST_I,
  // Register port.
  input wire logic [2:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic       WR_I,
  input wire logic       RD_I,
  input wire logic [7:0] RDATA_O,
  // Pads and peripherals.
  input wire logic [6:0] PB_GPIO_OUT_I,
  input wire logic [6:0] PB_PAD_OUT_O,
  input wire logic [6:0] PB_PAD_OE_O,
  input wire logic [6:0] PB_ANALOG_O,
  input wire logic [6:0] PC_PAD_OUT_O,
  input wire logic [6:0] PC_PAD_OE_O,
  input wire logic [3:0] PD_PAD_OUT_O,
  input wire logic [3:0] PD_PAD_OE_O,
  input wire logic       CTIMER_OUT_I,
  input wire logic       STIMER_OUT_I,
  input wire logic       CHIP_SEL_OE_I,
  input wire logic       SER_DATA_OUT_I,
  input wire logic       SER_TX_I
);
  // All checks run on the one clock and pause while reset is held.
  default clocking dc @(posedge CLK_I);
  endclocking
  default disable iff (SRST_I);

  // Register port: read data, stored bytes, refused bits, reset.
  a_read_data_idle: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
    else $error("read data not zero outside read answer cycle");
  a_write_read_back: assert property (
    WR_I && ADDR_I inside {3'h0, 3'h2, 3'h4} ##1 RD_I && ADDR_I == $past(ADDR_I) |=> RDATA_O == $past(WDATA_I, 2))
    else $error("full register did not read back written byte");
  a_narrow_top_zero: assert property (
    RD_I && ADDR_I inside {3'h1, 3'h3, 3'h5} |=> RDATA_O[7:6] == 2'b00)
    else $error("unimplemented top bits read nonzero");
  a_unmapped_reads_zero: assert property (RD_I && ADDR_I[2:1] == 2'b11 |=> RDATA_O == 8'h00)
    else $error("unmapped index read nonzero");
  a_reset_clears_all: assert property (
    $fell(SRST_I) |-> RDATA_O == 8'h00 && PB_PAD_OE_O == 7'h00 && PC_PAD_OE_O == 7'h00 && PD_PAD_OE_O == 4'h0)
    else $error("outputs not cleared by reset");

  // Pad steering two edges after a selector write; B4 follows the port latch one edge later.
  a_b3_compact_timer: assert property (
    WR_I && ADDR_I == 3'h0 && WDATA_I[7:6] == 2'b01 |-> ##2 PB_PAD_OE_O[3] && PB_PAD_OUT_O[3] == $past(CTIMER_OUT_I))
    else $error("port B line 3 not driven by compact timer");
  a_b2_standard_timer: assert property (
    WR_I && ADDR_I == 3'h0 && WDATA_I[5:4] == 2'b01 |-> ##2 PB_PAD_OE_O[2] && PB_PAD_OUT_O[2] == $past(STIMER_OUT_I))
    else $error("port B line 2 not driven by standard timer");
  a_b0_analog_hand: assert property (
    WR_I && ADDR_I == 3'h0 && WDATA_I[1:0] != 2'b00 |-> ##2 PB_ANALOG_O[0] && !PB_PAD_OE_O[0])
    else $error("port B line 0 not handed to analog side");
  a_b5_chip_select: assert property (
    WR_I && ADDR_I == 3'h1 && WDATA_I[3:2] == 2'b01 |-> ##2 PB_PAD_OE_O[5] == $past(CHIP_SEL_OE_I))
    else $error("port B line 5 enable not from chip select");
  a_c3_serial_out: assert property (
    WR_I && ADDR_I == 3'h2 && WDATA_I[7:6] == 2'b10 |-> ##2 PC_PAD_OE_O[3] && PC_PAD_OUT_O[3] == $past(SER_DATA_OUT_I))
    else $error("port C line 3 not driven by serial data out");
  a_c0_transmit_out: assert property (
    WR_I && ADDR_I == 3'h2 && WDATA_I[1:0] == 2'b01 |-> ##2 PC_PAD_OE_O[0] && PC_PAD_OUT_O[0] == $past(SER_TX_I))
    else $error("port C line 0 not driven by transmit line");
  a_d3_compact_timer: assert property (
    WR_I && ADDR_I == 3'h4 && WDATA_I[7:6] == 2'b01 |-> ##2 PD_PAD_OE_O[3] && PD_PAD_OUT_O[3] == $past(CTIMER_OUT_I))
    else $error("port D line 3 not driven by compact timer");
  a_b4_latch_path: assert property (!$past(SRST_I) |-> PB_PAD_OUT_O[4] == $past(PB_GPIO_OUT_I[4]))
    else $error("port B line 4 does not follow port latch");
endmodule

bind pfs_pin_function_selector pfs_sel_checker pfs_sel_checker_i (
  .CLK_I(CLK_I), .SRST_I(SRST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
  .RDATA_O(RDATA_O), .PB_GPIO_OUT_I(PB_GPIO_OUT_I), .PB_PAD_OUT_O(PB_PAD_OUT_O), .PB_PAD_OE_O(PB_PAD_OE_O),
  .PB_ANALOG_O(PB_ANALOG_O), .PC_PAD_OUT_O(PC_PAD_OUT_O), .PC_PAD_OE_O(PC_PAD_OE_O),
  .PD_PAD_OUT_O(PD_PAD_OUT_O), .PD_PAD_OE_O(PD_PAD_OE_O), .CTIMER_OUT_I(CTIMER_OUT_I),
  .STIMER_OUT_I(STIMER_OUT_I), .CHIP_SEL_OE_I(CHIP_SEL_OE_I), .SER_DATA_OUT_I(SER_DATA_OUT_I), .SER_TX_I(SER_TX_I)
);

// [test/test_pin_function_selector.sv]
// Self-checking bench for the pin function selector.
// Assumes a 25 MHz clock and register writes visible at the pads two edges later.
`timescale 1ns/1ps
module test_pin_function_selector;
  import pfs_pkg::*;
  // One pin row: address, field low bit, port (1 B, 2 C, 3 D), line, class per code 3..0.
  typedef struct packed {logic [2:0] a; logic [2:0] f; logic [1:0] p; logic [2:0] n; logic [7:0] cls;} pfs_row_s;
  pfs_row_s   rows [11] = '{
    '{3'h0, 3'h6, 2'h1, 3'h3, 8'hA4}, '{3'h0, 3'h4, 2'h1, 3'h2, 8'hA4}, '{3'h0, 3'h2, 2'h1, 3'h1, 8'hA8},
    '{3'h0, 3'h0, 2'h1, 3'h0, 8'hA8}, '{3'h1, 3'h2, 2'h1, 3'h5, 8'hA4}, '{3'h2, 3'h6, 2'h2, 3'h3, 8'h90},
    '{3'h2, 3'h4, 2'h2, 3'h2, 8'h90}, '{3'h2, 3'h2, 2'h2, 3'h1, 8'hAC}, '{3'h2, 3'h0, 2'h2, 3'h0, 8'hA4},
    '{3'h3, 3'h0, 2'h2, 3'h4, 8'hB0}, '{3'h4, 3'h6, 2'h3, 3'h3, 8'hA4}};
  // Source pins per input source bit as {port, line}, default then alternate.
  logic [4:0] src_def [6] = '{5'h19, 5'h16, 5'h15, 5'h14, 5'h08, 5'h09};
  logic [4:0] src_alt [6] = '{5'h11, 5'h0D, 5'h0E, 5'h03, 5'h01, 5'h02};
  logic       clk      = 1'b0;
  logic       srst     = 1'b1;
  logic [2:0] addr     = 3'h0;
  logic [7:0] wdata    = 8'h00;
  logic       wr       = 1'b0;
  logic       rd       = 1'b0;
  logic [3:1] pa       = 3'h0;
  logic [6:0] pb       = 7'h00;
  logic [6:0] pc       = 7'h00;
  logic [3:0] pd       = 4'h0;
  logic [6:0] gpio_out = 7'h00;
  logic [6:0] gpio_oe  = 7'h7F;
  logic       periph   = 1'b1;
  logic       cs_oe    = 1'b1;
  logic [7:0] rdata;
  logic [6:0] pb_out, pb_oe, pb_ana, pc_out, pc_oe, pc_ana;
  logic [3:0] pd_out, pd_oe, pd_ana;
  logic [5:0] routed;
  logic       stim_clk;
  logic [7:0] d;
  logic [2:0] view, expv;
  logic [1:0] c, cls;
  int         failures = 0;
  int         compares = 0;

  // Device under test with every input driven by the bench.
  pfs_pin_function_selector pfs_pin_function_selector_i (
    .CLK_I(clk), .SRST_I(srst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .PA_PAD_I(pa), .PB_PAD_I(pb), .PB_GPIO_OUT_I(gpio_out), .PB_GPIO_OE_I(gpio_oe),
    .PB_PAD_OUT_O(pb_out), .PB_PAD_OE_O(pb_oe), .PB_ANALOG_O(pb_ana),
    .PC_PAD_I(pc), .PC_GPIO_OUT_I(gpio_out), .PC_GPIO_OE_I(gpio_oe),
    .PC_PAD_OUT_O(pc_out), .PC_PAD_OE_O(pc_oe), .PC_ANALOG_O(pc_ana),
    .PD_PAD_I(pd), .PD_GPIO_OUT_I(gpio_out[3:0]), .PD_GPIO_OE_I(gpio_oe[3:0]),
    .PD_PAD_OUT_O(pd_out), .PD_PAD_OE_O(pd_oe), .PD_ANALOG_O(pd_ana),
    .CTIMER_OUT_I(periph), .STIMER_OUT_I(periph), .CHIP_SEL_OUT_I(periph), .CHIP_SEL_OE_I(cs_oe),
    .SER_DATA_OUT_I(periph), .SER_TX_I(periph), .EXT_IRQ_ZERO_O(routed[4]), .EXT_IRQ_ONE_O(routed[5]),
    .STIMER_CLK_IN_O(stim_clk), .SER_DATA_IN_O(routed[3]), .SER_CLK_IN_O(routed[2]),
    .CHIP_SEL_IN_O(routed[1]), .SER_RX_O(routed[0]));

  // Clock of 40 ns period.
  always #20 clk = ~clk;

  // Counts a comparison and reports a mismatch at once.
  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Reads one register; the answer stands only in the cycle after the strobe.
  task rd_chk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("read data", exp, rdata);
  endtask

  // Writes one register and reads it back with no gap.
  task wr_rd(input logic [2:0] a, input logic [7:0] dat, input logic [7:0] exp);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= dat;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("read back", exp, rdata);
  endtask

  // Drives one pad, chosen as {port, line}, at the current edge.
  task set_pad(input logic [4:0] s, input logic v);
    case (s[4:3])
      2'h0: pa[s[2:0]] <= v;
      2'h1: pb[s[2:0]] <= v;
      2'h2: pc[s[2:0]] <= v;
      default: pd[s[1:0]] <= v;
    endcase
  endtask

  // Prints the verdict and ends the run.
  task summarize();
    if (failures == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (6000) @(posedge clk);
    failures++;
    summarize();
  end

  // Main sequence.
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    for (int a = 0; a < 8; a++) rd_chk(3'(a), 8'h00);
    // Every code of every steered pin, ending back on the I/O code.
    foreach (rows[r]) begin
      for (int k = 1; k <= 4; k++) begin
        c = 2'(k);
        d = 8'(c) << rows[r].f;
        wr_rd(rows[r].a, d, d);
        @(posedge clk);
        periph <= ~k[0]; // The next code sees the other peripheral level.
        #1;
        cls = rows[r].cls[2*c +: 2];
        case (rows[r].p)
          2'h1: view = {pb_oe[rows[r].n], pb_out[rows[r].n], pb_ana[rows[r].n]};
          2'h2: view = {pc_oe[rows[r].n], pc_out[rows[r].n], pc_ana[rows[r].n]};
          default: view = {pd_oe[rows[r].n[1:0]], pd_out[rows[r].n[1:0]], pd_ana[rows[r].n[1:0]]};
        endcase
        expv = (cls == 2'h0) ? 3'h4 : (cls == 2'h1) ? {1'b1, k[0], 1'b0} : (cls == 2'h2) ? 3'h1 : 3'h0;
        chk("pad view", {5'h00, expv}, {5'h00, view & (cls[1] ? 3'h5 : 3'h7)});
      end
    end
    chk("latch-only drive", 8'h7F, {1'b0, pb_oe[6], pb_oe[4], pc_oe[6:5], pd_oe[2:0]});
    // Shared inputs are set as inputs in the direction latch; latch data is set to all ones.
    @(posedge clk);
    gpio_oe <= 7'h00;
    gpio_out <= 7'h7F;
    for (int b = 0; b < 6; b++) begin
      for (int s = 0; s < 2; s++) begin
        for (int v = 0; v < 2; v++) begin
          wr_rd(3'h5, 8'(s) << b, 8'(s) << b);
          @(posedge clk);
          set_pad(s[0] ? src_alt[b] : src_def[b], v[0]);
          set_pad(s[0] ? src_def[b] : src_alt[b], !v[0]);
          repeat (8) @(posedge clk);
          #1;
          chk("routed input", {7'h00, v[0]}, {7'h00, routed[b]});
          @(posedge clk);
          pa <= 3'h0;
          pb <= 7'h00;
          pc <= 7'h00;
          pd <= 4'h0;
        end
      end
    end
    // Timer clock input reaches the timer only on the I/O code.
    @(posedge clk);
    pb[2] <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    chk("timer clock io", 8'h01, {7'h00, stim_clk});
    wr_rd(3'h0, 8'h10, 8'h10);
    repeat (8) @(posedge clk);
    #1;
    chk("timer clock off", 8'h00, {7'h00, stim_clk});
    chk("latch-only data", 8'h7F, {1'b0, pb_out[6], pb_out[4], pc_out[6:5], pd_out[2:0]});
    chk("latch-only release", 8'h00, {1'b0, pb_oe[6], pb_oe[4], pc_oe[6:5], pd_oe[2:0]});
    // All ones into every index, then a reset in mid-run.
    for (int a = 0; a < 8; a++) wr_rd(3'(a), 8'hFF, (a >= 6) ? 8'h00 : a[0] ? 8'h3F : 8'hFF);
    @(posedge clk);
    #1;
    chk("analog after ones", 8'h2F, {1'b0, pb_ana});
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    for (int a = 0; a < 8; a++) rd_chk(3'(a), 8'h00);
    @(posedge clk);
    #1;
    chk("analog after reset", 8'h00, {1'b0, pb_ana | pc_ana});
    summarize();
  end
endmodule
